// ===== rtl/nor_timing_pkg.sv
// constants, state codes and carrier structs of the nor strobe timing engine
// assumes a single functional clock; shared by the engine, the flash model and the bench
package nor_timing_pkg;

  localparam int TW  = 5;   // width of one programmed timing field
  localparam int CW  = 10;  // width of the access cycle counter
  localparam int AW  = 27;  // word address width
  localparam int DW  = 16;  // data bus width
  localparam int NCS = 8;   // chip selects
  localparam int CSW = 3;   // chip select index width
  localparam int BW  = 2;   // beat index width, up to four page beats

  localparam logic [CW-1:0]  CNT_RST    = 10'h000;
  localparam logic [CW-1:0]  CNT_ONE    = 10'h001;
  localparam logic [BW-1:0]  BEAT_RST   = 2'h0;
  localparam logic [BW-1:0]  BEAT_ONE   = 2'h1;
  localparam logic [AW-1:0]  ADDR_RST   = 27'h0000000;
  localparam logic [AW-1:0]  ADDR_ONE   = 27'h0000001;
  localparam logic [DW-1:0]  DATA_RST   = 16'h0000;
  localparam logic [1:0]     BE_IDLE    = 2'h3;
  localparam logic [NCS-1:0] CS_IDLE    = 8'hFF;
  localparam logic           STROBE_OFF = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACC  = 2'b01,
    ST_GAP  = 2'b10
  } acc_state_e;

  typedef struct packed {
    logic [TW-1:0] read_access_cycles;
    logic [TW-1:0] page_access_cycles;
    logic          timing_scale_bit;
    logic [TW-1:0] cs_assert_time;
    logic [TW-1:0] cs_read_release_time;
    logic [TW-1:0] cs_write_release_time;
    logic [TW-1:0] adv_assert_time;
    logic [TW-1:0] adv_read_release_time;
    logic [TW-1:0] adv_write_release_time;
    logic [TW-1:0] oe_assert_time;
    logic [TW-1:0] oe_deassert_time;
    logic [TW-1:0] we_assert_time;
    logic [TW-1:0] we_deassert_time;
    logic [TW-1:0] read_cycle_count;
    logic [TW-1:0] write_cycle_count;
    logic [TW-1:0] cycle_gap_count;
    logic          cs_half_cycle_shift;
    logic          adv_half_cycle_shift;
    logic          oe_half_cycle_shift;
    logic          we_half_cycle_shift;
  } timing_cfg_s;

  typedef struct packed {
    logic           valid;
    logic           write;
    logic [CSW-1:0] cs_idx;
    logic [AW-1:0]  addr;
    logic [1:0]     be_n;
    logic [DW-1:0]  wdata;
    logic [BW-1:0]  beats_m1;
  } req_s;

  typedef struct packed {
    logic          valid;
    logic          last;
    logic [DW-1:0] data;
  } rd_s;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [1:0]    be_n;
    logic [DW-1:0] wdata;
    logic          data_oe;
  } mem_out_s;

endpackage

// ===== rtl/half_shift.sv
// half-cycle strobe shifter: picks a level or its falling-edge copy
// assumes lvl comes straight from rising-edge flops of the same clock
`timescale 1ns/1ps
module half_shift #(
  parameter int W = 1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] lvl,
  input  wire logic         shift,
  output logic      [W-1:0] pin
);

  logic [W-1:0] neg_q;

  // the falling edge gives the half cycle without a faster clock
  always_ff @(negedge mclk or negedge nrst) begin
    if (!nrst) begin
      neg_q <= '1;
    end else begin
      neg_q <= lvl;
    end
  end

  // only a mux of two flops; shift is static during an access
  assign pin = shift ? neg_q : lvl;

endmodule

// ===== rtl/nor_strobe_engine.sv
// asynchronous nor flash access engine: strobes timed from counters
// assumes cfg is held stable while req_ready is low; memory pins are 2-state
//
// How it works
// - first read word sampled read_access_cycles scaled cycles after start
// - later page words sampled every page_access_cycles scaled cycles
// - chip select low until release time, bursts add (n-1) page times
// - address valid latch released at its read or write release time
// - address, byte enables, data at start; chip select at its time
// - address valid latch asserted at adv_assert_time scaled
// - output enable asserted at oe_assert_time scaled
// - single read releases output enable at oe_deassert_time scaled
// - burst read release point extended by (n-1) page times
// - write enable asserted at we_assert_time scaled
// - write enable released at we_deassert_time scaled
// - address kept invalid cycle_gap_count scaled cycles between accesses
// - page read addresses two to four stepped page_access_cycles scaled apart; the last held to the end
// - byte enables valid for the cycle count plus burst extension
// - eight active-low chip selects sharing one timing set
// - data direction stays internal, shown only as data output enable
// - all strobes timed from mclk, no clock driven to the memory
`timescale 1ns/1ps
module nor_strobe_engine #(
  parameter int MAX_BEATS = 4
) (
  input  wire logic                                 mclk,
  input  wire logic                                 nrst,
  input  wire nor_timing_pkg::timing_cfg_s          cfg,
  input  wire nor_timing_pkg::req_s                 req,
  output logic                                      req_ready,
  output nor_timing_pkg::rd_s                       rd,
  output nor_timing_pkg::mem_out_s                  mem,
  input  wire logic [nor_timing_pkg::DW-1:0]        mem_rdata,
  output logic      [nor_timing_pkg::NCS-1:0]       cs_n,
  output logic                                      adv_n,
  output logic                                      oe_n,
  output logic                                      we_n
);

  // refused at elaboration: the beat counter cannot count further
  if (MAX_BEATS < 1 || MAX_BEATS > (1 << nor_timing_pkg::BW)) begin
    $error("MAX_BEATS out of range for the beat counter");
  end

  typedef struct packed {
    nor_timing_pkg::acc_state_e               st;
    logic [nor_timing_pkg::CW-1:0]            cnt;
    logic [nor_timing_pkg::CW-1:0]            gap_left;
    logic [nor_timing_pkg::BW-1:0]            beat;
    logic [nor_timing_pkg::BW-1:0]            nm1;
    logic                                     write;
    logic [nor_timing_pkg::CSW-1:0]           csi;
    nor_timing_pkg::mem_out_s                 mem;
    logic [nor_timing_pkg::NCS-1:0]           cs_lvl;
    logic                                     adv_lvl;
    logic                                     oe_lvl;
    logic                                     we_lvl;
    nor_timing_pkg::rd_s                      rd;
    logic                                     ready;
    logic [nor_timing_pkg::DW-1:0]            sync1;
    logic [nor_timing_pkg::DW-1:0]            sync2;
  } eng_s;

  localparam eng_s ENG_RST = '{
    st:      nor_timing_pkg::ST_IDLE,
    cnt:     nor_timing_pkg::CNT_RST,
    gap_left: nor_timing_pkg::CNT_RST,
    beat:    nor_timing_pkg::BEAT_RST,
    nm1:     nor_timing_pkg::BEAT_RST,
    write:   1'b0,
    csi:     3'h0,
    mem:     '{addr:    nor_timing_pkg::ADDR_RST,
               be_n:    nor_timing_pkg::BE_IDLE,
               wdata:   nor_timing_pkg::DATA_RST,
               data_oe: 1'b0},
    cs_lvl:  nor_timing_pkg::CS_IDLE,
    adv_lvl: nor_timing_pkg::STROBE_OFF,
    oe_lvl:  nor_timing_pkg::STROBE_OFF,
    we_lvl:  nor_timing_pkg::STROBE_OFF,
    rd:      '{valid: 1'b0, last: 1'b0, data: nor_timing_pkg::DATA_RST},
    ready:   1'b1,
    sync1:   nor_timing_pkg::DATA_RST,
    sync2:   nor_timing_pkg::DATA_RST
  };

  // field scaled by the granularity factor, which is 1 or 2
  function automatic logic [nor_timing_pkg::CW-1:0] scl(
    input logic [nor_timing_pkg::TW-1:0] f,
    input logic                          g
  );
    scl = {{(nor_timing_pkg::CW - nor_timing_pkg::TW){1'b0}}, f} << g;
  endfunction

  // scaled page time times a beat count
  function automatic logic [nor_timing_pkg::CW-1:0] mulb(
    input logic [nor_timing_pkg::CW-1:0] p,
    input logic [nor_timing_pkg::BW-1:0] k
  );
    mulb = p * {{(nor_timing_pkg::CW - nor_timing_pkg::BW){1'b0}}, k};
  endfunction

  eng_s q;
  eng_s d;

  logic                           start;
  logic                           wr;
  logic                           act;
  logic [nor_timing_pkg::BW-1:0]  nm1;
  logic [nor_timing_pkg::CSW-1:0] csi;
  logic [nor_timing_pkg::CW-1:0]  t;
  logic [nor_timing_pkg::CW-1:0]  pg;
  logic [nor_timing_pkg::CW-1:0]  ext;
  logic [nor_timing_pkg::CW-1:0]  cs_on;
  logic [nor_timing_pkg::CW-1:0]  cs_off;
  logic [nor_timing_pkg::CW-1:0]  adv_on;
  logic [nor_timing_pkg::CW-1:0]  adv_off;
  logic [nor_timing_pkg::CW-1:0]  oe_on;
  logic [nor_timing_pkg::CW-1:0]  oe_off;
  logic [nor_timing_pkg::CW-1:0]  we_on;
  logic [nor_timing_pkg::CW-1:0]  we_off;
  logic [nor_timing_pkg::CW-1:0]  end_t;
  logic [nor_timing_pkg::CW-1:0]  samp_t;
  logic [nor_timing_pkg::CW-1:0]  gap_t;

  // every edge is a compare of one counter against a scaled field
  always_comb begin
    start   = req.valid && (q.st == nor_timing_pkg::ST_IDLE);
    wr      = start ? req.write : q.write;
    nm1     = start ? req.beats_m1 : q.nm1;
    csi     = start ? req.cs_idx : q.csi;
    t       = (q.st == nor_timing_pkg::ST_ACC) ?
              q.cnt + nor_timing_pkg::CNT_ONE : nor_timing_pkg::CNT_RST;
    pg      = scl(cfg.page_access_cycles, cfg.timing_scale_bit);
    ext     = mulb(pg, nm1);
    cs_on   = scl(cfg.cs_assert_time, cfg.timing_scale_bit);
    cs_off  = scl(wr ? cfg.cs_write_release_time : cfg.cs_read_release_time,
                  cfg.timing_scale_bit) + ext;
    adv_on  = scl(cfg.adv_assert_time, cfg.timing_scale_bit);
    adv_off = scl(wr ? cfg.adv_write_release_time : cfg.adv_read_release_time,
                  cfg.timing_scale_bit);
    oe_on   = scl(cfg.oe_assert_time, cfg.timing_scale_bit);
    oe_off  = scl(cfg.oe_deassert_time, cfg.timing_scale_bit) + ext;
    we_on   = scl(cfg.we_assert_time, cfg.timing_scale_bit);
    we_off  = scl(cfg.we_deassert_time, cfg.timing_scale_bit);
    end_t   = scl(wr ? cfg.write_cycle_count : cfg.read_cycle_count,
                  cfg.timing_scale_bit) + ext;
    samp_t  = scl(cfg.read_access_cycles, cfg.timing_scale_bit)
              + mulb(pg, q.beat);
    gap_t   = scl(cfg.cycle_gap_count, cfg.timing_scale_bit);
    act     = (start || q.st == nor_timing_pkg::ST_ACC) && (t < end_t);
  end

  always_comb begin
    d            = q;
    d.rd.valid   = 1'b0;
    d.sync1      = mem_rdata;
    d.sync2      = q.sync1;
    // gap counted apart from cnt so the gap check does not lean on it
    d.gap_left   = (q.gap_left == nor_timing_pkg::CNT_RST) ?
                   nor_timing_pkg::CNT_RST :
                   q.gap_left - nor_timing_pkg::CNT_ONE;
    case (q.st)
      nor_timing_pkg::ST_IDLE: begin
        if (start) begin
          d.st          = nor_timing_pkg::ST_ACC;
          d.cnt         = nor_timing_pkg::CNT_RST;
          d.beat        = nor_timing_pkg::BEAT_RST;
          d.nm1         = req.beats_m1;
          d.write       = req.write;
          d.csi         = req.cs_idx;
          d.mem.addr    = req.addr;
          d.mem.be_n    = req.be_n;
          d.mem.wdata   = req.wdata;
          d.mem.data_oe = req.write;
        end
      end
      nor_timing_pkg::ST_ACC: begin
        d.cnt = t;
        if (!q.write && t == samp_t) begin
          d.rd.valid = 1'b1;
          d.rd.last  = (q.beat == q.nm1);
          d.rd.data  = q.sync2;
          if (q.beat != q.nm1) begin
            d.beat     = q.beat + nor_timing_pkg::BEAT_ONE;
            d.mem.addr = q.mem.addr + nor_timing_pkg::ADDR_ONE;
          end
        end
        if (t == end_t) begin
          d.st          = (gap_t == nor_timing_pkg::CNT_RST) ?
                          nor_timing_pkg::ST_IDLE : nor_timing_pkg::ST_GAP;
          d.cnt         = nor_timing_pkg::CNT_RST;
          d.mem.addr    = nor_timing_pkg::ADDR_RST;
          d.mem.be_n    = nor_timing_pkg::BE_IDLE;
          d.mem.data_oe = 1'b0;
          d.gap_left    = gap_t;
        end
      end
      nor_timing_pkg::ST_GAP: begin
        d.cnt = q.cnt + nor_timing_pkg::CNT_ONE;
        if (q.cnt + nor_timing_pkg::CNT_ONE >= gap_t) begin
          d.st = nor_timing_pkg::ST_IDLE;
        end
      end
      default: begin
        d.st = nor_timing_pkg::ST_IDLE;
      end
    endcase
    // one select line low; all eight share the same compare
    d.cs_lvl = nor_timing_pkg::CS_IDLE;
    if (act && t >= cs_on && t < cs_off) begin
      d.cs_lvl[csi] = 1'b0;
    end
    d.adv_lvl = !(act && t >= adv_on && t < adv_off);
    d.oe_lvl  = !(act && !wr && t >= oe_on && t < oe_off);
    d.we_lvl  = !(act && wr && t >= we_on && t < we_off);
    d.ready   = (d.st == nor_timing_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      q <= ENG_RST;
    end else begin
      q <= d;
    end
  end

  assign req_ready = q.ready;
  assign rd        = q.rd;
  assign mem       = q.mem;

  // strobes leave on mclk edges only; no clock pin exists
  half_shift #(.W(nor_timing_pkg::NCS)) u_cs (
    .mclk  (mclk),
    .nrst  (nrst),
    .lvl   (q.cs_lvl),
    .shift (cfg.cs_half_cycle_shift),
    .pin   (cs_n)
  );
  half_shift #(.W(1)) u_adv (
    .mclk  (mclk),
    .nrst  (nrst),
    .lvl   (q.adv_lvl),
    .shift (cfg.adv_half_cycle_shift),
    .pin   (adv_n)
  );
  half_shift #(.W(1)) u_oe (
    .mclk  (mclk),
    .nrst  (nrst),
    .lvl   (q.oe_lvl),
    .shift (cfg.oe_half_cycle_shift),
    .pin   (oe_n)
  );
  half_shift #(.W(1)) u_we (
    .mclk  (mclk),
    .nrst  (nrst),
    .lvl   (q.we_lvl),
    .shift (cfg.we_half_cycle_shift),
    .pin   (we_n)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence sample_edge_s;
    q.st == nor_timing_pkg::ST_ACC && !q.write && t == samp_t;
  endsequence

  sequence beat_left_s;
    q.beat != q.nm1;
  endsequence

  first_sample_a: assert property (
    sample_edge_s and q.beat == nor_timing_pkg::BEAT_RST
    |=> rd.valid && q.cnt == scl(cfg.read_access_cycles, cfg.timing_scale_bit)
  ) else $error("first read word not sampled at access time");

  page_step_a: assert property (
    sample_edge_s ##0 beat_left_s
    |=> !rd.last && q.mem.addr == $past(q.mem.addr) + nor_timing_pkg::ADDR_ONE
  ) else $error("page beat did not advance");

  cs_low_a: assert property (
    q.st == nor_timing_pkg::ST_ACC && q.cs_lvl[q.csi]
    && t == cs_on && t < cs_off |=> !q.cs_lvl[q.csi]
  ) else $error("chip select not asserted at its time");

  cs_release_a: assert property (
    q.st == nor_timing_pkg::ST_ACC && t == cs_off
    |=> q.cs_lvl == nor_timing_pkg::CS_IDLE
  ) else $error("chip select held past its release");

  adv_pulse_a: assert property (
    act && t == adv_on && adv_on < adv_off |=> !q.adv_lvl
  ) else $error("address latch not asserted");

  oe_window_a: assert property (
    act && !wr && t == oe_off |=> q.oe_lvl
  ) else $error("output enable not released");

  we_window_a: assert property (
    act && wr && t >= we_on && t < we_off |=> !q.we_lvl ##0 q.oe_lvl
  ) else $error("write enable outside its window");

  gap_hold_a: assert property (
    q.st == nor_timing_pkg::ST_GAP
    |-> q.mem.be_n == nor_timing_pkg::BE_IDLE && !q.mem.data_oe
        && q.mem.addr == nor_timing_pkg::ADDR_RST
  ) else $error("address not invalid during the gap");

  gap_length_a: assert property (
    start |-> q.gap_left <= nor_timing_pkg::CNT_ONE
  ) else $error("next access taken inside the gap");

endmodule

// ===== tb/nor_flash_model.sv
// flash part on the far side: answers reads on the data pins
// assumes a non-multiplexed address; adv_n is not needed by this part
`timescale 1ns/1ps
module nor_flash_model #(
  parameter logic [15:0] KEY = 16'h5A3C
) (
  input  wire logic                     mclk,
  input  wire logic [7:0]               cs_n,
  input  wire logic                     oe_n,
  input  wire nor_timing_pkg::mem_out_s mem,
  input  wire logic                     lat,
  output logic      [15:0]              mem_rdata
);
  logic [26:0] addr_q;
  logic        drive;

  assign drive = !oe_n && !(&cs_n) && !mem.data_oe;
  initial mem_rdata = 16'hC3A5;
  // slow mode wants one more cycle of stable address before answering
  // a released bus toggles, so a late sample never sees a stale word
  always @(posedge mclk) begin
    addr_q <= mem.addr;
    if (drive && (!lat || mem.addr == addr_q))
      mem_rdata <= mem.addr[15:0] ^ KEY;
    else
      mem_rdata <= ~mem_rdata;
  end
endmodule

// ===== tb/async_nor_strobe_timing_test.sv
// bench of the nor strobe engine: random timings, single and page accesses
// assumes the flash model answers within the programmed access windows
`timescale 1ns/1ps
module async_nor_strobe_timing_test;
  localparam logic [15:0] KEY = 16'h5A3C;
  logic                        mclk = 1'b0;
  logic                        nrst = 1'b0;
  nor_timing_pkg::timing_cfg_s cfg;
  nor_timing_pkg::req_s        req;
  logic                        req_ready;
  nor_timing_pkg::rd_s         rd;
  nor_timing_pkg::mem_out_s    mem;
  logic [15:0]                 mem_rdata;
  logic [7:0]                  cs_n;
  logic                        adv_n;
  logic                        oe_n;
  logic                        we_n;
  logic                        lat = 1'b0;
  logic [31:0]                 seed = 32'h9118;
  int                          miscompares = 0;
  int                          tests_run = 0;
  int                          cycles = 0;

  nor_strobe_engine uut (.mclk(mclk), .nrst(nrst), .cfg(cfg), .req(req),
    .req_ready(req_ready), .rd(rd), .mem(mem), .mem_rdata(mem_rdata),
    .cs_n(cs_n), .adv_n(adv_n), .oe_n(oe_n), .we_n(we_n));
  nor_flash_model #(.KEY(KEY)) flash (.mclk(mclk), .cs_n(cs_n),
    .oe_n(oe_n), .mem(mem), .lat(lat), .mem_rdata(mem_rdata));

  always #5 mclk = ~mclk;

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // a hang is cut at a limit well above 40 worst-case accesses
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 8000) begin
      miscompares = miscompares + 1;
      stop_test();
    end
  end

  function automatic logic [31:0] rnd(int m);
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed % m;
  endfunction

  function automatic logic lo(int t, int a, int b);
    return t >= a && t < b;
  endfunction

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // timings drawn so that every strobe ends inside its cycle
  task automatic newcfg();
    int cs, av, ar, oe, acc, of, cr, we, wo, cw;
    cs = rnd(3);
    av = cs + rnd(2);
    ar = av + 1 + rnd(3);
    oe = av + rnd(2);
    acc = oe + 5 + rnd(3); // slow flash answer plus two sync flops
    of = acc + 1 + rnd(2);
    cr = of + rnd(2);
    we = cs + rnd(2);
    wo = we + 1 + rnd(3);
    cw = (wo > ar ? wo : ar) + rnd(2);
    cfg.read_access_cycles = 5'(acc);
    cfg.page_access_cycles = 5'(6 + rnd(2));
    cfg.timing_scale_bit = 1'(rnd(2));
    cfg.cs_assert_time = 5'(cs);
    cfg.cs_read_release_time = 5'(cr);
    cfg.cs_write_release_time = 5'(cw);
    cfg.adv_assert_time = 5'(av);
    cfg.adv_read_release_time = 5'(ar);
    cfg.adv_write_release_time = 5'(ar);
    cfg.oe_assert_time = 5'(oe);
    cfg.oe_deassert_time = 5'(of);
    cfg.we_assert_time = 5'(we);
    cfg.we_deassert_time = 5'(wo);
    cfg.read_cycle_count = 5'(cr + rnd(2));
    cfg.write_cycle_count = 5'(cw + rnd(2));
    cfg.cycle_gap_count = 5'(rnd(3));
    cfg.cs_half_cycle_shift = 1'(rnd(2));
    cfg.adv_half_cycle_shift = 1'(rnd(2));
    cfg.oe_half_cycle_shift = 1'(rnd(2));
    cfg.we_half_cycle_shift = 1'(rnd(2));
    lat = 1'(rnd(2));
  endtask

  // one access from the falling edge before its take to the end of its gap
  task automatic access(logic wr, int n, logic [2:0] idx);
    int s, p, h, ext, cyc, fin, k, ka, crel;
    logic rv;
    nor_timing_pkg::req_s r;
    for (int w = 0; w < 8 && req_ready !== 1'b1; w++)
      @(negedge mclk);
    check("ready", req_ready, 1'b1);
    newcfg();
    s = cfg.timing_scale_bit + 1;
    p = cfg.page_access_cycles * s;
    h = cfg.read_access_cycles * s;
    ext = (n - 1) * p;
    crel = wr ? cfg.cs_write_release_time : cfg.cs_read_release_time;
    cyc = (wr ? cfg.write_cycle_count : cfg.read_cycle_count) * s + ext;
    fin = cyc + cfg.cycle_gap_count * s;
    r = {1'b1, wr, idx, 27'(rnd(32'h8000000)), 2'(rnd(3)),
         16'(rnd(32'h10000)), 2'(n - 1)};
    req = r;
    for (int t = 0; t <= fin; t++) begin
      @(posedge mclk);
      #1;
      check("cs_n", cs_n, nor_timing_pkg::CS_IDLE & ~(8'(lo(t -
        cfg.cs_half_cycle_shift, cfg.cs_assert_time * s, crel * s + ext))
        << r.cs_idx));
      check("adv_n", adv_n, !lo(t - cfg.adv_half_cycle_shift,
        cfg.adv_assert_time * s, (wr ? cfg.adv_write_release_time :
        cfg.adv_read_release_time) * s));
      check("oe_n", oe_n, !(!wr && lo(t - cfg.oe_half_cycle_shift,
        cfg.oe_assert_time * s, cfg.oe_deassert_time * s + ext)));
      check("we_n", we_n, !(wr && lo(t - cfg.we_half_cycle_shift,
        cfg.we_assert_time * s, cfg.we_deassert_time * s)));
      check("be_n", mem.be_n, t < cyc ? r.be_n : 2'h3);
      if (t >= cyc)
        check("gap addr", mem.addr, 27'h0000000);
      check("busy", req_ready, t == fin);
      if (t == 0) begin
        check("addr", mem.addr, r.addr);
        check("data_oe", mem.data_oe, wr);
        if (wr)
          check("wdata", mem.wdata, r.wdata);
      end
      k = t < h ? 0 : (t - h) / p;
      rv = !wr && t >= h && (t - h) % p == 0 && k < n;
      ka = (wr || t < h) ? 0 : (k + 1 < n ? k + 1 : n - 1);
      if (t < cyc)
        check("beat addr", mem.addr, 27'(r.addr + 27'(ka)));
      check("rd valid", rd.valid, rv);
      if (rv) begin
        check("rd last", rd.last, k == n - 1);
        check("rd data", rd.data, 16'(r.addr + 27'(k)) ^ KEY);
      end
      @(negedge mclk);
      if (t == 0) begin
        req.addr = ~r.addr;
        req.write = ~wr;
      end
      if (t == fin - 2)
        req.valid = 1'b0;
    end
  endtask

  initial begin
    cfg = '0;
    req = '0;
    repeat (10) @(negedge mclk);
    check("rst cs_n", cs_n, nor_timing_pkg::CS_IDLE);
    check("rst strobes", {adv_n, oe_n, we_n}, 3'h7);
    check("rst be_n", mem.be_n, nor_timing_pkg::BE_IDLE);
    check("rst rd", {rd.valid, mem.data_oe, req_ready}, 3'h1);
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    // first three: page read, page write, single read; then random
    for (int i = 0; i < 40; i++)
      access(i < 3 ? i == 1 : 1'(rnd(2)), i < 3 ? (i == 2 ? 1 : 4) :
        rnd(4) + 1, 3'(i));
    stop_test();
  end
endmodule
